// ===== src/pmc_defines.svh
// Constants of the power mode control block.
// Offsets, bit positions, reset values and timing figures.
// Assumes a 200 MHz clock and 5-bit register addresses.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Register offsets on the management interface
`define PMC_REG_BASIC_CONTROL 5'h00
`define PMC_REG_BASIC_STATUS 5'h01
`define PMC_REG_FE_CONTROL 5'h11
`define PMC_REG_EXPANDED_CONTROL 5'h18
`define PMC_REG_PHY_CONTROL_TWO 5'h1f

// Basic control fields
`define PMC_BC_SOFT_RESET 15
`define PMC_BC_LOOPBACK 14
`define PMC_BC_SPEED 13
`define PMC_BC_ANEG_EN 12
`define PMC_BC_POWER_DOWN 11
`define PMC_BC_ISOLATE 10
`define PMC_BC_RESTART_ANEG 9
`define PMC_BC_DUPLEX 8
`define PMC_BC_COL_TEST 7
// Other fields
`define PMC_BS_LINK_UP 2
`define PMC_FE_SLOW_OSC 5
`define PMC_EXP_EDPD_OFF 11
`define PMC_PC2_POWER_SAVE 10

// Reset values (strapped fields are loaded after reset release)
`define PMC_RST_BASIC 16'h0000
`define PMC_RST_FE 16'h0000
`define PMC_RST_EXPANDED 16'h0800
`define PMC_RST_PC2 16'h0000

// Management frame figures
`define PMC_PREAMBLE_BITS 6'd32
`define PMC_HDR_LAST 4'd12
`define PMC_DATA_LAST 4'd15
`define PMC_OP_READ 2'b10
`define PMC_OP_WRITE 2'b01

// Timing
`define PMC_CLK_MHZ 200
`define PMC_NLP_PERIOD_US 16
`define PMC_EDPD_PERIOD_US 1000
`define PMC_PULSE_WIDTH_NS 100

`endif

// ===== src/pmc_mdio_slave.sv
// Serial management slave walking read and write frames.
// Assumes a synchronous management clock far slower than clock_in,
// so each of its edges is a one-cycle event.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"

module pmc_mdio_slave
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n_out,
   // Own address
   input wire logic [2:0] phy_addr_in,
   // Register side
   output logic [4:0] reg_addr_out,
   input wire logic [15:0] rd_data_in,
   output logic wr_out,
   output logic [15:0] wr_data_out
);

   pmc_mstate_e st_q;
   logic mdc_q;
   logic [5:0] ones_q;
   logic [3:0] cnt_q;
   logic [12:0] hdr_q;
   logic [15:0] sh_q;
   logic rd_q;
   logic hit_q;
   logic rise;
   logic fall;
   logic [12:0] hdr_w;

   assign rise = mdc_in & ~mdc_q;
   assign fall = ~mdc_in & mdc_q;
   assign hdr_w = {hdr_q[11:0], mdio_in};

   // Edge reference for the management clock
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc_in;
      end
   end

   // Frame walker, advanced on rising management clock edges
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= PMC_MS_IDLE;
         ones_q <= 6'h00;
         cnt_q <= 4'h0;
         hdr_q <= 13'h0000;
         sh_q <= 16'h0000;
         rd_q <= 1'b0;
         hit_q <= 1'b0;
         reg_addr_out <= 5'h00;
         wr_out <= 1'b0;
         wr_data_out <= 16'h0000;
      end else begin
         wr_out <= 1'b0;
         if (rise) begin
            case (st_q)
               PMC_MS_IDLE: begin
                  // Start of frame needs a full preamble of ones
                  if (mdio_in) begin
                     if (ones_q != `PMC_PREAMBLE_BITS) begin
                        ones_q <= ones_q + 6'h01;
                     end
                  end else begin
                     if (ones_q == `PMC_PREAMBLE_BITS) begin
                        st_q <= PMC_MS_HDR;
                     end
                     ones_q <= 6'h00;
                     cnt_q <= 4'h0;
                  end
               end
               PMC_MS_HDR: begin
                  hdr_q <= hdr_w;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `PMC_HDR_LAST) begin
                     // Layout: start bit, op[1:0], phy[4:0], reg[4:0]
                     reg_addr_out <= hdr_w[4:0];
                     rd_q <= hdr_w[11:10] == `PMC_OP_READ;
                     hit_q <= hdr_w[12] &&
                        (hdr_w[9:5] == {2'b00, phy_addr_in} ||
                         hdr_w[9:5] == 5'h00);
                     cnt_q <= 4'h0;
                     if (hdr_w[12] && (hdr_w[11:10] == `PMC_OP_READ ||
                         hdr_w[11:10] == `PMC_OP_WRITE)) begin
                        st_q <= PMC_MS_TA;
                     end else begin
                        st_q <= PMC_MS_IDLE;
                     end
                  end
               end
               PMC_MS_TA: begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h0) begin
                     sh_q <= rd_data_in;
                  end else begin
                     cnt_q <= 4'h0;
                     st_q <= rd_q ? PMC_MS_RDATA : PMC_MS_WDATA;
                  end
               end
               PMC_MS_RDATA: begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `PMC_DATA_LAST) begin
                     st_q <= PMC_MS_IDLE;
                  end
               end
               PMC_MS_WDATA: begin
                  sh_q <= {sh_q[14:0], mdio_in};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `PMC_DATA_LAST) begin
                     wr_data_out <= {sh_q[14:0], mdio_in};
                     wr_out <= hit_q;
                     st_q <= PMC_MS_IDLE;
                  end
               end
               default: begin
                  st_q <= PMC_MS_IDLE;
               end
            endcase
         end
      end
   end

   // Read answer, changed on falling edges so it is stable at the rise.
   // Still answers in power down, since only this interface stays awake.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mdio_out <= 1'b1;
         mdio_oe_n_out <= 1'b1;
      end else if (fall) begin
         if (hit_q && rd_q && st_q == PMC_MS_TA && cnt_q == 4'h1) begin
            mdio_out <= 1'b0;
            mdio_oe_n_out <= 1'b0;
         end else if (hit_q && st_q == PMC_MS_RDATA) begin
            mdio_out <= sh_q[`PMC_DATA_LAST - cnt_q];
            mdio_oe_n_out <= 1'b0;
         end else begin
            mdio_out <= 1'b1;
            mdio_oe_n_out <= 1'b1;
         end
      end
   end

endmodule : pmc_mdio_slave
`default_nettype wire

// ===== src/pmc_pkg.sv
// Types shared by the power mode control block and its management slave.
// Assumes pmc_defines.svh supplies the numeric constants.
package pmc_pkg;

   // Power state of the transceiver
   typedef enum logic [1:0] {
      PMC_MODE_NORMAL = 2'b00,
      PMC_MODE_SAVE = 2'b01,
      PMC_MODE_EDPD = 2'b10,
      PMC_MODE_DOWN = 2'b11
   } pmc_mode_e;

   // Management frame walker
   typedef enum logic [2:0] {
      PMC_MS_IDLE = 3'b000,
      PMC_MS_HDR = 3'b001,
      PMC_MS_TA = 3'b010,
      PMC_MS_RDATA = 3'b011,
      PMC_MS_WDATA = 3'b100
   } pmc_mstate_e;

endpackage : pmc_pkg

// ===== src/pmc_power_ctrl.sv
// Power mode control of a 10/100 transceiver.
// Control registers and the power state that they select.
// Assumes synchronous link and strap inputs.
// Assumes the analog blocks follow the enables.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"

// Function
// RULE1 - Bit 10 of phy control two enables saving with aneg on and no link.
// RULE2 - Saving keeps only transmitter, energy detector and PLL powered.
// RULE3 - Saving is off after power-up until software sets it.
// RULE4 - Expanded control bit 11 at zero enables EDPD with aneg on, no link.
// RULE5 - EDPD keeps only transmitter and energy detector, the PLL stops.
// RULE6 - In EDPD link pulses go out at a longer interval.
// RULE7 - EDPD is off after power-up until software enables it.
// RULE8 - Writing one to bit 11 of basic control enters power down.
// RULE9 - Power down stops all but the management interface, which works.
// RULE10 - Power down ends when bit 11 of basic control returns to zero.
// RULE11 - Front-end bit 5 swaps the crystal reference for the slow clock.
// RULE12 - Slow oscillator plus power down is the lowest power state.
// RULE13 - Exit slow clock: clear bit 5, then power down, then reset bit.
// RULE14 - A reset write in power down only wakes; a second one resets.
// RULE15 - The software reset bit clears itself and reads back zero.
// RULE16 - Saving modes follow the link monitor, ending on link or aneg off.
module pmc_power_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned NLP_CYCLES = `PMC_NLP_PERIOD_US * `PMC_CLK_MHZ,
   parameter int unsigned EDPD_CYCLES = `PMC_EDPD_PERIOD_US * `PMC_CLK_MHZ
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n_out,
   // Straps
   input wire logic [2:0] strap_phy_addr_in,
   input wire logic strap_speed_in,
   input wire logic strap_aneg_in,
   input wire logic strap_duplex_n_in,
   input wire logic strap_isolate_in,
   // Link monitor
   input wire logic link_up_in,
   // Block power enables
   output logic rx_blocks_on_out,
   output logic tx_on_out,
   output logic energy_detect_on_out,
   output logic pll_on_out,
   // Clock reference and state
   output logic slow_osc_sel_out,
   output logic lowest_power_out,
   output logic [1:0] power_mode_out,
   // Link pulses
   output logic link_pulse_out,
   // Control towards the rest of the transceiver
   output logic soft_reset_out,
   output logic restart_aneg_out,
   output logic loopback_out,
   output logic speed_100_out,
   output logic aneg_enable_out,
   output logic isolate_out,
   output logic full_duplex_out,
   output logic col_test_out
);

   localparam int unsigned PULSE_CYCLES =
      (`PMC_PULSE_WIDTH_NS * `PMC_CLK_MHZ + 999) / 1000;

   logic [4:0] reg_addr;
   logic wr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [15:0] basic_q;
   logic [15:0] fe_q;
   logic [15:0] exp_q;
   logic [15:0] pc2_q;
   logic strap_load_q;
   logic soft_rst_req;
   pmc_mode_e mode_q;
   pmc_mode_e mode_d;
   logic [31:0] nlp_cnt_q;
   logic [31:0] nlp_limit;
   logic [7:0] pw_cnt_q;
   logic no_link;

   // Management slave; it has no power gate of its own
   pmc_mdio_slave u_mdio ( // RULE9
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .mdc_in(mdc_in),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe_n_out(mdio_oe_n_out),
      .phy_addr_in(strap_phy_addr_in),
      .reg_addr_out(reg_addr),
      .rd_data_in(rd_data),
      .wr_out(wr),
      .wr_data_out(wr_data)
   );

   // A reset write acts as a chip reset only outside power down
   assign soft_rst_req = wr && reg_addr == `PMC_REG_BASIC_CONTROL &&
      wr_data[`PMC_BC_SOFT_RESET] && !basic_q[`PMC_BC_POWER_DOWN]; // RULE14

   // Straps are caught after reset release and after each chip reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_load_q <= 1'b1;
      end else begin
         strap_load_q <= soft_rst_req; // RULE14
      end
   end

   // Basic control; the reset and restart bits are never stored
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         basic_q <= `PMC_RST_BASIC;
      end else if (soft_rst_req) begin
         basic_q <= `PMC_RST_BASIC;
      end else if (strap_load_q) begin
         basic_q[`PMC_BC_SPEED] <= strap_speed_in;
         basic_q[`PMC_BC_ANEG_EN] <= strap_aneg_in;
         basic_q[`PMC_BC_DUPLEX] <= ~strap_duplex_n_in;
         basic_q[`PMC_BC_ISOLATE] <= strap_isolate_in;
      end else if (wr && reg_addr == `PMC_REG_BASIC_CONTROL) begin
         basic_q <= wr_data;
         basic_q[`PMC_BC_SOFT_RESET] <= 1'b0; // RULE15
         basic_q[`PMC_BC_RESTART_ANEG] <= 1'b0;
         if (wr_data[`PMC_BC_SOFT_RESET]) begin
            // First reset write in power down only wakes the chip
            basic_q[`PMC_BC_POWER_DOWN] <= 1'b0; // RULE14
         end
      end
   end

   // Front-end control, slow oscillator select
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fe_q <= `PMC_RST_FE;
      end else if (soft_rst_req) begin
         fe_q <= `PMC_RST_FE;
      end else if (wr && reg_addr == `PMC_REG_FE_CONTROL) begin
         fe_q <= wr_data; // RULE11
      end
   end

   // Expanded control; energy-detect power down starts disabled
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exp_q <= `PMC_RST_EXPANDED; // RULE7
      end else if (soft_rst_req) begin
         exp_q <= `PMC_RST_EXPANDED;
      end else if (wr && reg_addr == `PMC_REG_EXPANDED_CONTROL) begin
         exp_q <= wr_data; // RULE4
      end
   end

   // Phy control two; power saving starts disabled
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc2_q <= `PMC_RST_PC2; // RULE3
      end else if (soft_rst_req) begin
         pc2_q <= `PMC_RST_PC2;
      end else if (wr && reg_addr == `PMC_REG_PHY_CONTROL_TWO) begin
         pc2_q <= wr_data; // RULE1
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      case (reg_addr)
         `PMC_REG_BASIC_CONTROL: rd_data = basic_q; // RULE15
         `PMC_REG_BASIC_STATUS: begin
            rd_data = 16'h0000;
            rd_data[`PMC_BS_LINK_UP] = link_up_in;
         end
         `PMC_REG_FE_CONTROL: rd_data = fe_q;
         `PMC_REG_EXPANDED_CONTROL: rd_data = exp_q;
         `PMC_REG_PHY_CONTROL_TWO: rd_data = pc2_q;
         default: rd_data = 16'h0000;
      endcase
   end

   // Power state choice; energy detect wins since it saves more
   assign no_link = basic_q[`PMC_BC_ANEG_EN] && !link_up_in; // RULE16
   always_comb begin
      if (basic_q[`PMC_BC_POWER_DOWN]) begin
         mode_d = PMC_MODE_DOWN; // RULE8 RULE10
      end else if (no_link && !exp_q[`PMC_EXP_EDPD_OFF]) begin
         mode_d = PMC_MODE_EDPD; // RULE4
      end else if (no_link && pc2_q[`PMC_PC2_POWER_SAVE]) begin
         mode_d = PMC_MODE_SAVE; // RULE1
      end else begin
         mode_d = PMC_MODE_NORMAL; // RULE16
      end
   end

   // Mode register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= PMC_MODE_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Block enables decoded from the registered mode
   always_comb begin
      case (mode_q)
         PMC_MODE_NORMAL: begin
            rx_blocks_on_out = 1'b1;
            tx_on_out = 1'b1;
            energy_detect_on_out = 1'b1;
            pll_on_out = 1'b1;
         end
         PMC_MODE_SAVE: begin
            rx_blocks_on_out = 1'b0; // RULE2
            tx_on_out = 1'b1;
            energy_detect_on_out = 1'b1;
            pll_on_out = 1'b1;
         end
         PMC_MODE_EDPD: begin
            rx_blocks_on_out = 1'b0; // RULE5
            tx_on_out = 1'b1;
            energy_detect_on_out = 1'b1;
            pll_on_out = 1'b0;
         end
         default: begin
            rx_blocks_on_out = 1'b0; // RULE9
            tx_on_out = 1'b0;
            energy_detect_on_out = 1'b0;
            pll_on_out = 1'b0;
         end
      endcase
   end

   assign power_mode_out = mode_q;
   assign slow_osc_sel_out = fe_q[`PMC_FE_SLOW_OSC]; // RULE11
   assign lowest_power_out = slow_osc_sel_out &&
      mode_q == PMC_MODE_DOWN; // RULE12

   // Link pulse interval; stretched while in energy-detect power down
   assign nlp_limit = (mode_q == PMC_MODE_EDPD) ?
      EDPD_CYCLES - 32'd1 : NLP_CYCLES - 32'd1; // RULE6

   // Pulse timer runs only while searching for a partner
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nlp_cnt_q <= 32'h0000_0000;
         pw_cnt_q <= 8'h00;
         link_pulse_out <= 1'b0;
      end else if (mode_q == PMC_MODE_DOWN || link_up_in) begin
         nlp_cnt_q <= 32'h0000_0000;
         pw_cnt_q <= 8'h00;
         link_pulse_out <= 1'b0;
      end else begin
         // A shorter limit after leaving EDPD restarts the count at once
         if (nlp_cnt_q >= nlp_limit) begin
            nlp_cnt_q <= 32'h0000_0000;
            pw_cnt_q <= PULSE_CYCLES[7:0];
            link_pulse_out <= 1'b1; // RULE6
         end else begin
            nlp_cnt_q <= nlp_cnt_q + 32'd1;
            if (pw_cnt_q > 8'h01) begin
               pw_cnt_q <= pw_cnt_q - 8'h01;
            end else begin
               pw_cnt_q <= 8'h00;
               link_pulse_out <= 1'b0;
            end
         end
      end
   end

   // One-cycle control pulses
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         soft_reset_out <= 1'b0;
         restart_aneg_out <= 1'b0;
      end else begin
         soft_reset_out <= soft_rst_req; // RULE13 RULE14
         restart_aneg_out <= wr && !soft_rst_req &&
            reg_addr == `PMC_REG_BASIC_CONTROL &&
            wr_data[`PMC_BC_RESTART_ANEG];
      end
   end

   // Level controls straight from basic control
   assign loopback_out = basic_q[`PMC_BC_LOOPBACK];
   assign speed_100_out = basic_q[`PMC_BC_SPEED];
   assign aneg_enable_out = basic_q[`PMC_BC_ANEG_EN];
   assign isolate_out = basic_q[`PMC_BC_ISOLATE];
   assign full_duplex_out = basic_q[`PMC_BC_DUPLEX];
   assign col_test_out = basic_q[`PMC_BC_COL_TEST];

endmodule : pmc_power_ctrl
`default_nettype wire

// ===== verification/pmc_mdio_master.sv
// Management controller model: clocks read and write frames onto the
// management pins. Assumes a pull-up on the data line.
`timescale 1ns/1ps
`default_nettype none

module pmc_mdio_master (
   // Bench clock
   input wire logic clock_in,
   // Device drive of the data line
   input wire logic mdio_out,
   input wire logic mdio_oe_n_out,
   // Management pins towards the device
   output var logic mdc_out,
   output logic mdio_line_out
);
   logic drv_en = 1'b0;
   logic drv_bit = 1'b1;
   // Resolved line: device, else model, else the pull-up
   assign mdio_line_out = !mdio_oe_n_out ? mdio_out :
      (drv_en ? drv_bit : 1'b1);
   initial mdc_out = 1'b0;

   // One frame, five cycles per clock half; clock idles low afterwards
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
         input logic [4:0] r, input logic [15:0] wd,
         output logic [15:0] rd, output logic ta);
      logic [63:0] bits;
      bits = {32'hffffffff, 2'h1, op, phy, r, 2'h2, wd};
      rd = 16'h0;
      ta = 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(negedge clock_in);
         mdc_out = 1'b0;
         drv_en = !(op == 2'h2 && i > 45); // Released for read turnaround
         drv_bit = bits[63 - i];
         repeat (5) @(negedge clock_in);
         mdc_out = 1'b1;
         if (i == 47) ta = mdio_line_out;
         if (i > 47) rd[63 - i] = mdio_line_out;
         repeat (4) @(negedge clock_in);
      end
      @(negedge clock_in);
      mdc_out = 1'b0;
      drv_en = 1'b0;
   endtask : frame
endmodule : pmc_mdio_master
`default_nettype wire

// ===== verification/pmc_power_ctrl_bench.sv
// Self-checking bench of the power mode control block.
// Assumes the controller model drives the management pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
   mismatches++; $display("wrong value at %0t: got %h", $time, a); end end

module pmc_power_ctrl_bench
   import pmc_pkg::*;
;
   localparam int NLP = 40;
   localparam int EDPD = 100;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic mdc_in, mdio_in, mdio_out, mdio_oe_n_out;
   logic [2:0] addr = 3'h1;
   logic speed = 1'b0, aneg = 1'b0, dup_n = 1'b0, iso = 1'b0, link = 1'b0;
   logic rx, tx, ed, pll, slow, lowest, pulse, sr, ta;
   logic [1:0] mode;
   logic [15:0] lfsr_q = 16'h002c;
   logic [15:0] rd, bstrap;
   int mismatches = 0, n_compared = 0, cyc = 0, sr_n = 0, n;

   always #2.5 clock_in = ~clock_in;

   pmc_power_ctrl #(.NLP_CYCLES(NLP), .EDPD_CYCLES(EDPD)) pmc_power_ctrl_i (
      .clock_in, .rst_n_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_n_out,
      .strap_phy_addr_in(addr), .strap_speed_in(speed),
      .strap_aneg_in(aneg), .strap_duplex_n_in(dup_n),
      .strap_isolate_in(iso), .link_up_in(link), .rx_blocks_on_out(rx),
      .tx_on_out(tx), .energy_detect_on_out(ed), .pll_on_out(pll),
      .slow_osc_sel_out(slow), .lowest_power_out(lowest),
      .power_mode_out(mode), .link_pulse_out(pulse), .soft_reset_out(sr),
      .restart_aneg_out(), .loopback_out(), .speed_100_out(),
      .aneg_enable_out(), .isolate_out(), .full_duplex_out(),
      .col_test_out());
   pmc_mdio_master pmc_mdio_master_i (.clock_in, .mdio_out, .mdio_oe_n_out,
      .mdc_out(mdc_in), .mdio_line_out(mdio_in));

   // Reset pulses counted; a hang guard well above the expected run
   always @(posedge clock_in) begin
      if (sr === 1'b1) sr_n <= sr_n + 1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         conclude();
      end
   end

   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : step
   // Aneg, link, detect-off bit, saving bit to the expected mode
   function automatic logic [1:0] exp_mode(input logic a, l, e, s);
      if (a && !l && !e) return 2'h2;
      if (a && !l && s) return 2'h1;
      return 2'h0;
   endfunction : exp_mode
   function automatic logic [3:0] exp_en(input logic [1:0] m);
      case (m)
         2'h0: return 4'hf;
         2'h1: return 4'h7;
         2'h2: return 4'h6;
         default: return 4'h0;
      endcase
   endfunction : exp_en

   task automatic wr(input logic [4:0] r, input logic [15:0] d);
      pmc_mdio_master_i.frame(2'h1, {2'h0, addr}, r, d, rd, ta);
   endtask : wr
   task automatic rdc(input logic [4:0] r, input logic [15:0] e);
      pmc_mdio_master_i.frame(2'h2, {2'h0, addr}, r, 16'h0, rd, ta);
      `CHK(ta, 1'b0)
      `CHK(rd, e)
   endtask : rdc
   task automatic chk_mode(input logic [1:0] m);
      repeat (2) @(negedge clock_in);
      `CHK(mode, m)
      `CHK({rx, tx, ed, pll}, exp_en(m))
   endtask : chk_mode
   // Skip a running pulse, then measure width and rise-to-rise gap
   task automatic pulse_chk(input int per);
      int w, g;
      w = 0;
      g = 0;
      while (pulse && g < 300) begin @(negedge clock_in); g++; end
      while (!pulse && g < 600) begin @(negedge clock_in); g++; end
      while (pulse && w < 300) begin @(negedge clock_in); w++; end
      g = w;
      while (!pulse && g < 300) begin @(negedge clock_in); g++; end
      `CHK(w, 20)
      `CHK(g, per)
   endtask : pulse_chk
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   initial begin
      lfsr_q = step(lfsr_q);
      {iso, dup_n, aneg, speed} = lfsr_q[3:0];
      addr = {1'b0, lfsr_q[5:4]} + 3'h1;
      bstrap = {2'h0, speed, aneg, 1'h0, iso, 1'h0, !dup_n, 8'h0};
      repeat (16) @(negedge clock_in);
      rst_n_in = 1'b1;
      chk_mode(2'h0);
      rdc(5'h00, bstrap);
      rdc(5'h11, 16'h0000);
      rdc(5'h18, 16'h0800);
      rdc(5'h1f, 16'h0000);
      rdc(5'h05, 16'h0000);
      wr(5'h00, 16'h1000);
      wr(5'h1f, 16'h0400);
      chk_mode(2'h1);
      pulse_chk(NLP);
      link = 1'b1;
      chk_mode(2'h0);
      link = 1'b0;
      chk_mode(2'h1);
      wr(5'h18, 16'h0000);
      chk_mode(2'h2);
      pulse_chk(EDPD);
      wr(5'h00, 16'h0000);
      chk_mode(2'h0);
      // Deepest state, then the documented way back out
      wr(5'h00, 16'h1800);
      chk_mode(2'h3);
      wr(5'h11, 16'h0020);
      `CHK({slow, lowest}, 2'h3)
      rdc(5'h11, 16'h0020);
      `CHK(pulse, 1'b0)
      wr(5'h11, 16'h0000);
      `CHK({slow, lowest}, 2'h0)
      wr(5'h00, 16'h1000);
      chk_mode(2'h2);
      n = sr_n;
      wr(5'h00, 16'h8000);
      `CHK(sr_n, n + 1)
      rdc(5'h18, 16'h0800);
      rdc(5'h00, bstrap);
      // A reset write during power down only ends power down
      wr(5'h00, 16'h1800);
      chk_mode(2'h3);
      n = sr_n;
      wr(5'h00, 16'h9800);
      `CHK(sr_n, n)
      rdc(5'h00, 16'h1000);
      chk_mode(2'h0);
      wr(5'h00, 16'h8000);
      `CHK(sr_n, n + 1)
      rdc(5'h00, bstrap);
      // Foreign address ignored, broadcast accepted
      pmc_mdio_master_i.frame(2'h1, {2'h0, addr ^ 3'h7}, 5'h11, 16'h0020,
         rd, ta);
      `CHK(slow, 1'b0)
      pmc_mdio_master_i.frame(2'h1, 5'h00, 5'h11, 16'h0020, rd, ta);
      `CHK(slow, 1'b1)
      wr(5'h11, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         repeat (5) lfsr_q = step(lfsr_q);
         link = lfsr_q[0];
         wr(5'h00, lfsr_q & 16'h7580);
         wr(5'h18, {4'h0, lfsr_q[1], 11'h0});
         wr(5'h1f, {5'h0, lfsr_q[2], 10'h0});
         chk_mode(exp_mode(lfsr_q[12], link, lfsr_q[1], lfsr_q[2]));
      end
      conclude();
   end
endmodule : pmc_power_ctrl_bench
`default_nettype wire

// ===== verification/pmc_power_ctrl_monitor.sv
// Checker bound to the power mode control block.
// Assumes its ports and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module pmc_power_ctrl_monitor
   import pmc_pkg::*;
(
   // Clock, reset and management pins
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic mdc_in,
   input wire logic mdio_out,
   input wire logic mdio_oe_n_out,
   // Link and power state
   input wire logic link_up_in,
   input wire logic aneg_enable_out,
   input wire logic [1:0] power_mode_out,
   input wire logic rx_blocks_on_out,
   input wire logic tx_on_out,
   input wire logic energy_detect_on_out,
   input wire logic pll_on_out,
   input wire logic slow_osc_sel_out,
   input wire logic lowest_power_out,
   input wire logic link_pulse_out,
   // Register side effects
   input wire logic soft_reset_out,
   input wire logic loopback_out,
   input wire logic col_test_out
);
   logic [3:0] en;
   logic [1:0] m;
   // Enables in rx, tx, detector, pll order
   assign en = {rx_blocks_on_out, tx_on_out, energy_detect_on_out, pll_on_out};
   assign m = power_mode_out;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   save_enables_a:
      assert property (m == PMC_MODE_SAVE |-> en == 4'h7)
      else $error("saving mode enables wrong");
   edpd_enables_a:
      assert property (m == PMC_MODE_EDPD |-> en == 4'h6)
      else $error("detect mode enables wrong");
   down_all_off_a:
      assert property (m == PMC_MODE_DOWN |-> en == 4'h0)
      else $error("power down leaves a block on");
   // Mode is registered from the cause one cycle before
   link_ends_save_a:
      assert property (link_up_in || !aneg_enable_out |=>
         m != PMC_MODE_SAVE && m != PMC_MODE_EDPD)
      else $error("low power mode kept with link or no aneg");
   lowest_power_a:
      assert property (lowest_power_out ==
         (slow_osc_sel_out && m == PMC_MODE_DOWN))
      else $error("lowest power flag wrong");
   pulse_cause_a:
      assert property ($rose(link_pulse_out) |->
         !$past(link_up_in) && $past(m) != PMC_MODE_DOWN)
      else $error("link pulse without cause");
   reset_self_clears_a:
      assert property (soft_reset_out |=> !soft_reset_out)
      else $error("reset pulse longer than one cycle");
   reset_defaults_a:
      assert property (soft_reset_out |->
         !slow_osc_sel_out && !loopback_out && !col_test_out)
      else $error("soft reset left register bits set");
   ta_zero_a:
      assert property ($fell(mdio_oe_n_out) |-> !mdio_out)
      else $error("turnaround bit not zero");
   // Read data may only move one cycle after a clock fall
   data_after_fall_a:
      assert property (!mdio_oe_n_out && !$past(mdio_oe_n_out) &&
         $changed(mdio_out) |-> $past(mdc_in, 2) && !$past(mdc_in))
      else $error("read data moved off the clock fall");

   cover property (m == PMC_MODE_SAVE);
   cover property (m == PMC_MODE_EDPD);
   cover property (lowest_power_out);
   cover property ($fell(mdio_oe_n_out));
endmodule : pmc_power_ctrl_monitor

bind pmc_power_ctrl pmc_power_ctrl_monitor
   pmc_power_ctrl_monitor_i (.clock_in, .rst_n_in, .mdc_in, .mdio_out,
   .mdio_oe_n_out, .link_up_in, .aneg_enable_out, .power_mode_out,
   .rx_blocks_on_out, .tx_on_out, .energy_detect_on_out, .pll_on_out,
   .slow_osc_sel_out, .lowest_power_out, .link_pulse_out,
   .soft_reset_out, .loopback_out, .col_test_out);
`default_nettype wire
